// *** verilog/tcc_device.sv ***
// three 16-bit counters behind a byte command channel
// assumes count inputs are asynchronous pins; link bytes are on CLK_I
//
// Contract
// - mode command then high, low config bytes
// - high bits 6..4: 1-0-1 decrements counter 3..1
// - high bits 3..1: 1-0-1 increments counter 3..1
// - host keeps step bits at one normally
// - 3-bit mode per counter across both bytes
// - status keeps carry and borrow flags
// - status command returns one status byte
// - counter read returns high byte, then low
// - preload command plus 16-bit value loads counter
// - host sends preload high byte first
// - three reads yield six bytes, in order
// - mode 0: a rise counts up, b rise counts down
// - modes 1-5: quadrature, mode picks edges
// - mode 6: time low phase of input a
// - mode 7: count a, latch on b rise
`timescale 1ns/1ns
`default_nettype none
module tcc_device (
	input  wire logic                              CLK_I,
	input  wire logic                              RESET_N_I,
	input  wire logic                              CE_I,
	input  wire logic [tcc_pkg::TCC_NUM_CTR-1:0]   COUNT_INPUT_A_I,
	input  wire logic [tcc_pkg::TCC_NUM_CTR-1:0]   COUNT_INPUT_B_I,
	tcc_link_if.device                             LINK,
	output logic      [tcc_pkg::TCC_MODE_BITS-1:0] MODE_O
);
	import tcc_pkg::*;

	localparam int N = TCC_NUM_CTR;

	function automatic logic [1:0] cmd_ctr(input logic [7:0] c,
			input logic [7:0] base);
		logic [7:0] d;
		d = c - base;
		cmd_ctr = (d != 8'h00 && d <= 8'(N)) ? d[1:0] : 2'b00;
	endfunction

	// edges a counter reacts to: {a rise, a fall, b rise, b fall}
	function automatic logic [3:0] edge_mask(input tcc_mode_t m);
		case (m)
			MODE_QA_R:  edge_mask = 4'h8;
			MODE_QB_R:  edge_mask = 4'h2;
			MODE_QA_RF: edge_mask = 4'hC;
			MODE_QB_RF: edge_mask = 4'h3;
			MODE_Q_ALL: edge_mask = 4'hF;
			default:    edge_mask = 4'h0;
		endcase
	endfunction

	function automatic tcc_mode_t mode_of(input logic [TCC_MODE_BITS-1:0] v,
			input int k);
		mode_of = tcc_mode_t'(v[k*TCC_MODE_W +: TCC_MODE_W]);
	endfunction

	logic [N-1:0]             a_s1_r, a_s2_r, a_s3_r;
	logic [N-1:0]             b_s1_r, b_s2_r, b_s3_r;
	tcc_dev_state_t           st_r, st_nxt;
	logic [7:0]               hi_r;
	logic [TCC_MODE_BITS-1:0] mode_r;
	logic [2*N-1:0]           step_r;
	logic [1:0]               ld_idx_r;
	logic [7:0]               tx_lo_r;
	logic [7:0]               d2h_data_r;
	logic                     d2h_valid_r;
	logic [TCC_CTR_W-1:0]     cnt_r  [N];
	logic [TCC_CTR_W-1:0]     hold_r [N];
	logic [TCC_CTR_W-1:0]     rd_val [N];
	logic [N-1:0]             meas_r, carry_r, borrow_r;

	// pins pass two flops; the third stage only feeds edge detection
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			a_s1_r <= '0;
			a_s2_r <= '0;
			a_s3_r <= '0;
			b_s1_r <= '0;
			b_s2_r <= '0;
			b_s3_r <= '0;
		end else if (CE_I) begin
			a_s1_r <= COUNT_INPUT_A_I;
			a_s2_r <= a_s1_r;
			a_s3_r <= a_s2_r;
			b_s1_r <= COUNT_INPUT_B_I;
			b_s2_r <= b_s1_r;
			b_s3_r <= b_s2_r;
		end
	end

	// command decode
	wire       byte_in     = LINK.h2d_valid & CE_I;
	wire [7:0] rx          = LINK.h2d_data;
	wire [1:0] rd_n        = cmd_ctr(rx, TCC_CMD_RD_BASE);
	wire [1:0] ld_n        = cmd_ctr(rx, TCC_CMD_LD_BASE);
	wire       in_idle     = (st_r == ST_IDLE);
	wire       take_status = byte_in & in_idle & (rx == TCC_CMD_STATUS);
	wire       take_read   = byte_in & in_idle & (rd_n != 2'b00);
	wire       take_hi     = byte_in & ((st_r == ST_MODE_HI) |
	                                    (st_r == ST_LOAD_HI));
	wire       mode_done   = byte_in & (st_r == ST_MODE_LO);
	wire       load_done   = byte_in & (st_r == ST_LOAD_LO);
	wire       send_lo     = (st_r == ST_SEND_LO) & CE_I;
	wire [TCC_CTR_W-1:0] load_val = {hi_r, rx};
	wire [TCC_CTR_W-1:0] rd_word  = rd_val[rd_n - 2'b01];

	// step bits are active low; a step fires when a bit returns to one
	wire [2*N-1:0] step_new = {hi_r[TCC_HI_DEC_LSB +: N],
	                           hi_r[TCC_HI_INC_LSB +: N]};
	wire [2*N-1:0] step_ev  = mode_done ? (step_new & ~step_r) : '0;
	wire [N-1:0]   soft_inc = step_ev[N-1:0];
	wire [N-1:0]   soft_dec = step_ev[2*N-1:N];

	wire [7:0] status_byte;
	assign status_byte = {1'b0, borrow_r, 1'b0, carry_r};

	always_comb begin
		st_nxt = st_r;
		if (CE_I) begin
			case (st_r)
				ST_IDLE: begin
					if (take_read)
						st_nxt = ST_SEND_LO;
					else if (byte_in && rx == TCC_CMD_MODE)
						st_nxt = ST_MODE_HI;
					else if (byte_in && ld_n != 2'b00)
						st_nxt = ST_LOAD_HI;
				end
				ST_MODE_HI: if (byte_in) st_nxt = ST_MODE_LO;
				ST_MODE_LO: if (byte_in) st_nxt = ST_IDLE;
				ST_LOAD_HI: if (byte_in) st_nxt = ST_LOAD_LO;
				ST_LOAD_LO: if (byte_in) st_nxt = ST_IDLE;
				ST_SEND_LO: st_nxt = ST_IDLE;
				default:    st_nxt = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			st_r     <= ST_IDLE;
			hi_r     <= 8'h00;
			mode_r   <= '0;
			step_r   <= '1;
			ld_idx_r <= 2'b00;
		end else begin
			st_r <= st_nxt;
			if (take_hi)
				hi_r <= rx;
			if (mode_done) begin
				mode_r <= {hi_r[TCC_HI_MODE8], rx};
				step_r <= step_new;
			end
			if (byte_in && in_idle)
				ld_idx_r <= ld_n;
		end
	end

	// answer bytes: status, or counter high byte then low byte
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			d2h_valid_r <= 1'b0;
			d2h_data_r  <= 8'h00;
			tx_lo_r     <= 8'h00;
		end else if (CE_I) begin
			d2h_valid_r <= take_status | take_read | send_lo;
			if (take_status)
				d2h_data_r <= status_byte;
			else if (take_read) begin
				d2h_data_r <= rd_word[15:8];
				tx_lo_r    <= rd_word[7:0];
			end else if (send_lo)
				d2h_data_r <= tx_lo_r;
		end
	end

	assign LINK.d2h_data  = d2h_data_r;
	assign LINK.d2h_valid = d2h_valid_r;
	assign MODE_O         = mode_r;

	genvar k;
	generate
		for (k = 0; k < N; k++) begin : g_ctr
			wire       a    = a_s2_r[k];
			wire       b    = b_s2_r[k];
			wire       ar   = a & ~a_s3_r[k];
			wire       af   = ~a & a_s3_r[k];
			wire       br   = b & ~b_s3_r[k];
			wire       bf   = ~b & b_s3_r[k];
			tcc_mode_t m;
			wire [3:0] msk;
			wire       is_m0, is_pw, is_fq;
			wire       q_up, q_dn, hw_inc, hw_dec;
			wire       inc, dec, clr, latch, ld;
			wire       at_max, at_zero;
			wire [TCC_CTR_W-1:0] cnt_nxt;

			assign m     = mode_of(mode_r, k);
			assign msk   = edge_mask(m);
			assign is_m0 = (m == MODE_UPDN);
			assign is_pw = (m == MODE_PWIDTH);
			assign is_fq = (m == MODE_FREQ);
			// a leading b counts up on every selected edge
			assign q_up = (msk[3] & ar & ~b) | (msk[2] & af & b) |
			              (msk[1] & br & a) | (msk[0] & bf & ~a);
			assign q_dn = (msk[3] & ar & b) | (msk[2] & af & ~b) |
			              (msk[1] & br & ~a) | (msk[0] & bf & a);
			assign hw_inc = is_m0 ? ar :
			                is_pw ? (meas_r[k] & ~a & ~b) :
			                is_fq ? (ar & ~b) : q_up;
			assign hw_dec = is_m0 ? br :
			                is_pw ? (meas_r[k] & ~a & b) :
			                is_fq ? 1'b0 : q_dn;
			wire dec_both  = (hw_inc | soft_inc[k]) & (hw_dec | soft_dec[k]);
			assign inc     = (hw_inc | soft_inc[k]) & ~dec_both;
			assign dec     = (hw_dec | soft_dec[k]) & ~dec_both;
			assign clr     = (is_pw & af) | (is_fq & br);
			assign latch   = (is_pw & ar & meas_r[k]) | (is_fq & br);
			assign ld      = load_done & (ld_idx_r == 2'(k + 1));
			assign at_max  = (cnt_r[k] == TCC_CTR_MAX);
			assign at_zero = (cnt_r[k] == TCC_CTR_ZERO);
			// wraps modulo 2^16 by plain width truncation
			assign cnt_nxt = ld  ? load_val :
			                 clr ? TCC_CTR_ZERO :
			                 inc ? cnt_r[k] + 16'h0001 :
			                 dec ? cnt_r[k] - 16'h0001 : cnt_r[k];
			// timing modes report the held result, others the live count
			assign rd_val[k] = (is_pw | is_fq) ? hold_r[k] : cnt_r[k];

			always_ff @(posedge CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					cnt_r[k]    <= TCC_CTR_ZERO;
					hold_r[k]   <= TCC_CTR_ZERO;
					meas_r[k]   <= 1'b0;
					carry_r[k]  <= 1'b0;
					borrow_r[k] <= 1'b0;
				end else if (CE_I) begin
					cnt_r[k] <= cnt_nxt;
					if (latch)
						hold_r[k] <= cnt_r[k];
					meas_r[k] <= is_pw & (af | (meas_r[k] & ~ar));
					// a new event beats the clear of a status read
					carry_r[k]  <= (inc & ~ld & ~clr & at_max) |
					               (carry_r[k] & ~take_status);
					borrow_r[k] <= (dec & ~ld & ~clr & at_zero) |
					               (borrow_r[k] & ~take_status);
				end
			end
		end
	endgenerate
endmodule // tcc_device
`default_nettype wire

// *** shared/tcc_pkg.sv ***
// constants, field layouts and types shared by both ends of the counter link
// assumes one module clock shared by both ends; no file includes this twice
package tcc_pkg;
	localparam int          TCC_NUM_CTR     = 3;
	localparam int          TCC_CTR_W       = 16;
	localparam int          TCC_BYTE_W      = 8;
	localparam int          TCC_MODE_W      = 3;
	localparam int          TCC_MODE_BITS   = TCC_NUM_CTR * TCC_MODE_W;
	// command codes
	localparam logic [7:0]  TCC_CMD_STATUS  = 8'h00;
	localparam logic [7:0]  TCC_CMD_RD_BASE = 8'h00;
	localparam logic [7:0]  TCC_CMD_MODE    = 8'h80;
	localparam logic [7:0]  TCC_CMD_LD_BASE = 8'h80;
	// high-order configuration byte fields
	localparam int          TCC_HI_MODE8    = 0;
	localparam int          TCC_HI_INC_LSB  = 1;
	localparam int          TCC_HI_DEC_LSB  = 4;
	localparam logic [7:0]  TCC_HI_IDLE     = 8'h7E;
	// status byte fields
	localparam int          TCC_ST_CARRY    = 0;
	localparam int          TCC_ST_BORROW   = 4;
	// reference of the pulse-width mode equals the module clock rate
	localparam int          TCC_CLK_HZ      = 10_000_000;
	localparam int          TCC_REF_HZ      = 10_000_000;
	localparam int          TCC_REF_DIV     = TCC_CLK_HZ / TCC_REF_HZ;
	localparam logic [15:0] TCC_CTR_MAX     = 16'hFFFF;
	localparam logic [15:0] TCC_CTR_ZERO    = 16'h0000;

	typedef enum logic [2:0] {
		MODE_UPDN   = 3'b000,
		MODE_QA_R   = 3'b001,
		MODE_QB_R   = 3'b010,
		MODE_QA_RF  = 3'b011,
		MODE_QB_RF  = 3'b100,
		MODE_Q_ALL  = 3'b101,
		MODE_PWIDTH = 3'b110,
		MODE_FREQ   = 3'b111
	} tcc_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_MODE_HI = 3'b001,
		ST_MODE_LO = 3'b010,
		ST_LOAD_HI = 3'b011,
		ST_LOAD_LO = 3'b100,
		ST_SEND_LO = 3'b101
	} tcc_dev_state_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_TX   = 2'b01,
		H_RX   = 2'b10
	} tcc_host_state_t;

	typedef enum logic [1:0] {
		OP_MODE   = 2'b00,
		OP_STATUS = 2'b01,
		OP_READ   = 2'b10,
		OP_LOAD   = 2'b11
	} tcc_op_t;
endpackage

// *** shared/tcc_link_if.sv ***
// byte channel between the host firmware end and the counter device end
// assumes both ends run on the same clock; the testbench supplies it
`timescale 1ns/1ns
`default_nettype none
interface tcc_link_if;
	logic [7:0] h2d_data;
	logic       h2d_valid;
	logic [7:0] d2h_data;
	logic       d2h_valid;

	modport device (
		input  h2d_data,
		input  h2d_valid,
		output d2h_data,
		output d2h_valid
	);
	modport host (
		output h2d_data,
		output h2d_valid,
		input  d2h_data,
		input  d2h_valid
	);
endinterface
`default_nettype wire

// *** verilog/tcc_host.sv ***
// firmware end: turns user requests into command bytes, gathers answers
// assumes the device end shares CLK_I; user inputs are on that clock
`timescale 1ns/1ns
`default_nettype none
module tcc_host (
	input  wire logic                              CLK_I,
	input  wire logic                              RESET_N_I,
	input  wire logic                              CE_I,
	input  wire logic                              REQ_VALID_I,
	input  wire tcc_pkg::tcc_op_t                  REQ_OP_I,
	input  wire logic [1:0]                        REQ_CTR_I,
	input  wire logic [tcc_pkg::TCC_CTR_W-1:0]     REQ_DATA_I,
	input  wire logic [tcc_pkg::TCC_MODE_BITS-1:0] REQ_MODE_I,
	input  wire logic [tcc_pkg::TCC_NUM_CTR-1:0]   REQ_STEP_INC_I,
	input  wire logic [tcc_pkg::TCC_NUM_CTR-1:0]   REQ_STEP_DEC_I,
	output logic                                   REQ_READY_O,
	output logic                                   RESP_VALID_O,
	output logic      [tcc_pkg::TCC_CTR_W-1:0]     RESP_DATA_O,
	tcc_link_if.host                               LINK
);
	import tcc_pkg::*;

	tcc_host_state_t st_r;
	logic [47:0]     tx_q_r;
	logic [2:0]      tx_n_r;
	logic [1:0]      rx_n_r;
	logic [15:0]     rx_r;
	logic [7:0]      h2d_data_r;
	logic            h2d_valid_r;
	logic            resp_valid_r;
	logic [15:0]     resp_data_r;
	logic            ready_r;

	wire       take    = REQ_VALID_I & (st_r == H_IDLE) & CE_I;
	wire       has_stp = |{REQ_STEP_INC_I, REQ_STEP_DEC_I};
	// step bits idle at one; a step request drives its bit low once
	wire [7:0] hi_idle = TCC_HI_IDLE | 8'(REQ_MODE_I[TCC_MODE_BITS-1]);
	wire [7:0] hi_step = hi_idle & ~(8'(REQ_STEP_DEC_I) << TCC_HI_DEC_LSB)
	                             & ~(8'(REQ_STEP_INC_I) << TCC_HI_INC_LSB);
	wire [7:0] lo_mode = REQ_MODE_I[7:0];
	wire [7:0] ctr_n   = 8'(REQ_CTR_I);
	// a step request is sent as low then restored high: six bytes
	wire [47:0] q_mode = has_stp ?
		{TCC_CMD_MODE, hi_step, lo_mode, TCC_CMD_MODE, hi_idle, lo_mode} :
		{TCC_CMD_MODE, hi_idle, lo_mode, 24'h000000};
	wire [47:0] q_load = {TCC_CMD_LD_BASE + ctr_n, REQ_DATA_I, 24'h000000};
	wire [47:0] q_one  = {(REQ_OP_I == OP_STATUS) ? TCC_CMD_STATUS :
	                      TCC_CMD_RD_BASE + ctr_n, 40'h0000000000};
	wire [47:0] q_sel  = (REQ_OP_I == OP_MODE) ? q_mode :
	                     (REQ_OP_I == OP_LOAD) ? q_load : q_one;
	wire [2:0]  n_sel  = (REQ_OP_I == OP_MODE) ? (has_stp ? 3'h6 : 3'h3) :
	                     (REQ_OP_I == OP_LOAD) ? 3'h3 : 3'h1;
	wire [1:0]  r_sel  = (REQ_OP_I == OP_READ) ? 2'h2 :
	                     (REQ_OP_I == OP_STATUS) ? 2'h1 : 2'h0;
	wire        rx_in  = LINK.d2h_valid & CE_I;

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			st_r         <= H_IDLE;
			tx_q_r       <= '0;
			tx_n_r       <= 3'h0;
			rx_n_r       <= 2'h0;
			rx_r         <= 16'h0000;
			h2d_data_r   <= 8'h00;
			h2d_valid_r  <= 1'b0;
			resp_valid_r <= 1'b0;
			resp_data_r  <= 16'h0000;
			ready_r      <= 1'b1;
		end else if (CE_I) begin
			h2d_valid_r  <= 1'b0;
			resp_valid_r <= 1'b0;
			case (st_r)
				H_IDLE: if (take) begin
					tx_q_r <= q_sel;
					tx_n_r <= n_sel;
					rx_n_r <= r_sel;
					rx_r   <= 16'h0000;
					st_r   <= H_TX;
					ready_r <= 1'b0;
				end
				H_TX: begin
					h2d_valid_r <= 1'b1;
					h2d_data_r  <= tx_q_r[47:40];
					tx_q_r      <= {tx_q_r[39:0], 8'h00};
					tx_n_r      <= tx_n_r - 3'h1;
					if (tx_n_r == 3'h1)
						st_r <= H_RX;
				end
				H_RX: begin
					if (rx_in) begin
						rx_r   <= {rx_r[7:0], LINK.d2h_data};
						rx_n_r <= rx_n_r - 2'h1;
					end
					if (rx_n_r == 2'h0 || (rx_in && rx_n_r == 2'h1)) begin
						resp_valid_r <= 1'b1;
						resp_data_r  <= rx_in ? {rx_r[7:0], LINK.d2h_data}
						                      : rx_r;
						st_r         <= H_IDLE;
						ready_r      <= 1'b1;
					end
				end
				default: begin
					st_r    <= H_IDLE;
					ready_r <= 1'b1;
				end
			endcase
		end
	end

	assign LINK.h2d_data  = h2d_data_r;
	assign LINK.h2d_valid = h2d_valid_r;
	assign REQ_READY_O    = ready_r;
	assign RESP_VALID_O   = resp_valid_r;
	assign RESP_DATA_O    = resp_data_r;
endmodule // tcc_host
`default_nettype wire

// *** tb/tcc_asserts.sv ***
// link checker: watches the byte channel between host and device ends
// assumes one clock; tb_top instantiates it beside the link interface
`timescale 1ns/1ns
`default_nettype none
module tcc_asserts (
	input wire logic       CLK_I,
	input wire logic       RESET_N_I,
	input wire logic [7:0] h2d_data,
	input wire logic       h2d_valid,
	input wire logic [7:0] d2h_data,
	input wire logic       d2h_valid
);
	logic [1:0] param_cnt_r;
	logic [1:0] param_cnt_nxt;
	logic       query_r;
	wire        cmd_seen = h2d_valid && (param_cnt_r == 2'h0);
	wire        cmd_wr   = cmd_seen && (h2d_data >= 8'h80)
	                       && (h2d_data <= 8'h83);
	wire        cmd_rd   = cmd_seen && (h2d_data >= 8'h01)
	                       && (h2d_data <= 8'h03);
	wire        cmd_st   = cmd_seen && (h2d_data == 8'h00);
	wire        in_param = h2d_valid && (param_cnt_r != 2'h0);

	// parameter bytes carry any value, so they must not pass as commands
	assign param_cnt_nxt = cmd_wr ? 2'h2 :
	                       in_param ? param_cnt_r - 2'h1 : param_cnt_r;

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			param_cnt_r <= 2'h0;
			query_r     <= 1'b0;
		end else begin
			param_cnt_r <= param_cnt_nxt;
			query_r     <= cmd_rd || cmd_st;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);

	sequence s_two_bytes;
		d2h_valid [*2] ##1 !d2h_valid;
	endsequence
	sequence s_one_byte;
		d2h_valid ##1 !d2h_valid;
	endsequence

	property p_read_reply;
		cmd_rd |=> s_two_bytes;
	endproperty
	a_read_reply: assert property (p_read_reply)
		else $error("counter read did not give two bytes");
	property p_status_reply;
		cmd_st |=> s_one_byte;
	endproperty
	a_status_reply: assert property (p_status_reply)
		else $error("status read did not give one byte");
	property p_status_rsvd;
		cmd_st |=> (d2h_data[7] == 1'b0) && (d2h_data[3] == 1'b0);
	endproperty
	a_status_rsvd: assert property (p_status_rsvd)
		else $error("status byte has a spare bit set");
	property p_write_silent;
		cmd_wr |=> !d2h_valid [*3];
	endproperty
	a_write_silent: assert property (p_write_silent)
		else $error("device answered a write command");
	property p_param_follow;
		cmd_wr |-> ##[1:4] h2d_valid ##[1:4] h2d_valid;
	endproperty
	a_param_follow: assert property (p_param_follow)
		else $error("host did not send both parameter bytes");
	property p_host_gap;
		cmd_rd |=> !h2d_valid [*2];
	endproperty
	a_host_gap: assert property (p_host_gap)
		else $error("host sent a byte during a counter reply");
	property p_no_overlap;
		d2h_valid |-> !h2d_valid;
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("host byte collided with device reply");
	property p_reply_cause;
		$rose(d2h_valid) |-> query_r;
	endproperty
	a_reply_cause: assert property (p_reply_cause)
		else $error("device replied without a query");
endmodule // tcc_asserts
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench: host end and device end joined by the link
// assumes tcc_pkg, the link interface and both ends compile first
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import tcc_pkg::*;
	logic        CLK_I;
	logic        RESET_N_I;
	logic        REQ_VALID_I;
	tcc_op_t     REQ_OP_I;
	logic [1:0]  REQ_CTR_I;
	logic [15:0] REQ_DATA_I;
	logic [8:0]  REQ_MODE_I;
	logic [2:0]  REQ_STEP_INC_I;
	logic [2:0]  REQ_STEP_DEC_I;
	logic [2:0]  COUNT_INPUT_A_I;
	logic [2:0]  COUNT_INPUT_B_I;
	wire         REQ_READY_O;
	wire         RESP_VALID_O;
	wire  [15:0] RESP_DATA_O;
	wire  [8:0]  MODE_O;
	int          fails;
	int          tests_run;
	logic [31:0] seed;
	logic [15:0] got;
	logic [15:0] v;
	logic [15:0] val [3];
	logic [8:0]  modes;

	tcc_link_if tcc_link_if_i ();
	tcc_device tcc_device_i (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
		.CE_I(1'b1), .COUNT_INPUT_A_I(COUNT_INPUT_A_I),
		.COUNT_INPUT_B_I(COUNT_INPUT_B_I), .LINK(tcc_link_if_i),
		.MODE_O(MODE_O));
	tcc_host tcc_host_i (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CE_I(1'b1),
		.REQ_VALID_I(REQ_VALID_I), .REQ_OP_I(REQ_OP_I),
		.REQ_CTR_I(REQ_CTR_I), .REQ_DATA_I(REQ_DATA_I),
		.REQ_MODE_I(REQ_MODE_I), .REQ_STEP_INC_I(REQ_STEP_INC_I),
		.REQ_STEP_DEC_I(REQ_STEP_DEC_I), .REQ_READY_O(REQ_READY_O),
		.RESP_VALID_O(RESP_VALID_O), .RESP_DATA_O(RESP_DATA_O),
		.LINK(tcc_link_if_i));
	tcc_asserts tcc_asserts_i (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
		.h2d_data(tcc_link_if_i.h2d_data),
		.h2d_valid(tcc_link_if_i.h2d_valid),
		.d2h_data(tcc_link_if_i.d2h_data),
		.d2h_valid(tcc_link_if_i.d2h_valid));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// status byte: carry of counter k at bit k, borrow at bit k+4
	function automatic logic [15:0] exp_status(input logic [2:0] cy,
		input logic [2:0] bw);
		return {8'h00, 1'b0, bw, 1'b0, cy};
	endfunction

	// pulse width: the clock that sees the fall clears, later low clocks count
	function automatic logic [15:0] exp_pw(input int low, input logic down);
		return down ? 16'(0 - (low - 1)) : 16'(low - 1);
	endfunction

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e,
		input string m);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask

	// one user request; waits for the response pulse under a bound
	task automatic req(input tcc_op_t op, input logic [1:0] c,
		input logic [15:0] d, input logic [2:0] inc, input logic [2:0] dec);
		@(posedge CLK_I);
		REQ_VALID_I    <= 1'b1;
		REQ_OP_I       <= op;
		REQ_CTR_I      <= c;
		REQ_DATA_I     <= d;
		REQ_MODE_I     <= modes;
		REQ_STEP_INC_I <= inc;
		REQ_STEP_DEC_I <= dec;
		@(posedge CLK_I);
		REQ_VALID_I <= 1'b0;
		@(negedge CLK_I);
		chk({15'h0000, REQ_READY_O}, 16'h0000, "busy");
		repeat (40) begin
			if (RESP_VALID_O === 1'b1)
				break;
			@(negedge CLK_I);
		end
		chk({15'h0000, RESP_VALID_O}, 16'h0001, "response");
		chk({15'h0000, REQ_READY_O}, 16'h0001, "ready");
		got = RESP_DATA_O;
	endtask

	// n periods of a four-step pattern on the pins of counter k
	task automatic wave(input int k, input logic [3:0] pa,
		input logic [3:0] pb, input int n);
		repeat (n) begin
			for (int s = 0; s < 4; s++) begin
				@(posedge CLK_I);
				COUNT_INPUT_A_I <= (COUNT_INPUT_A_I & ~(3'b001 << k))
				                   | (3'(pa[s]) << k);
				COUNT_INPUT_B_I <= (COUNT_INPUT_B_I & ~(3'b001 << k))
				                   | (3'(pb[s]) << k);
				@(posedge CLK_I);
			end
		end
		// pin path has three clocks of latency
		repeat (6) @(posedge CLK_I);
	endtask

	initial begin
		CLK_I = 1'b0;
		forever #50 CLK_I = ~CLK_I;
	end

	initial begin
		repeat (5000) @(posedge CLK_I);
		fails++;
		test_done();
	end

	initial begin
		seed = 32'd44;
		fails = 0;
		tests_run = 0;
		modes = 9'h000;
		RESET_N_I = 1'b0;
		REQ_VALID_I = 1'b0;
		REQ_OP_I = OP_STATUS;
		REQ_CTR_I = 2'h1;
		REQ_DATA_I = 16'h0000;
		REQ_MODE_I = 9'h000;
		REQ_STEP_INC_I = 3'h0;
		REQ_STEP_DEC_I = 3'h0;
		COUNT_INPUT_A_I = 3'h0;
		COUNT_INPUT_B_I = 3'h0;
		repeat (16) @(posedge CLK_I);
		RESET_N_I <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			modes = {3'(m + 2), 3'(m + 1), 3'(m)};
			req(OP_MODE, 2'h0, 16'h0000, 3'h0, 3'h0);
			chk({7'h00, MODE_O}, {7'h00, modes}, "mode");
		end
		modes = 9'h000;
		req(OP_MODE, 2'h0, 16'h0000, 3'h0, 3'h0);
		for (int i = 0; i < 9; i++) begin
			v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'(rnd());
			val[i % 3] = v;
			req(OP_LOAD, 2'(i % 3 + 1), v, 3'h0, 3'h0);
			req(OP_READ, 2'(i % 3 + 1), 16'h0000, 3'h0, 3'h0);
			chk(got, v, "preload");
		end
		for (int k = 0; k < 3; k++) begin
			req(OP_READ, 2'(k + 1), 16'h0000, 3'h0, 3'h0);
			chk(got, val[k], "read all");
		end
		req(OP_STATUS, 2'h0, 16'h0000, 3'h0, 3'h0);
		chk(got, exp_status(3'h0, 3'h0), "status idle");
		for (int k = 0; k < 3; k++) begin
			req(OP_LOAD, 2'(k + 1), 16'hFFFF, 3'h0, 3'h0);
			req(OP_MODE, 2'h0, 16'h0000, 3'(1 << k), 3'h0);
			req(OP_READ, 2'(k + 1), 16'h0000, 3'h0, 3'h0);
			chk(got, 16'h0000, "step up wrap");
			req(OP_LOAD, 2'(k + 1), 16'h0000, 3'h0, 3'h0);
			req(OP_MODE, 2'h0, 16'h0000, 3'h0, 3'(1 << k));
			req(OP_READ, 2'(k + 1), 16'h0000, 3'h0, 3'h0);
			chk(got, 16'hFFFF, "step down wrap");
		end
		req(OP_STATUS, 2'h0, 16'h0000, 3'h0, 3'h0);
		chk(got, exp_status(3'h7, 3'h7), "status flags");
		req(OP_STATUS, 2'h0, 16'h0000, 3'h0, 3'h0);
		chk(got, exp_status(3'h0, 3'h0), "status cleared");
		v = 16'(rnd());
		req(OP_LOAD, 2'h3, v, 3'h0, 3'h0);
		wave(2, 4'b0011, 4'b0000, 5);
		wave(2, 4'b0000, 4'b0011, 2);
		req(OP_READ, 2'h3, 16'h0000, 3'h0, 3'h0);
		chk(got, v + 16'h0003, "mode 0 pins");
		modes = 9'h001;
		req(OP_MODE, 2'h0, 16'h0000, 3'h0, 3'h0);
		v = 16'(rnd());
		req(OP_LOAD, 2'h1, v, 3'h0, 3'h0);
		wave(0, 4'b0011, 4'b0110, 4);
		wave(0, 4'b0110, 4'b0011, 1);
		req(OP_READ, 2'h1, 16'h0000, 3'h0, 3'h0);
		chk(got, v + 16'h0003, "quadrature");
		// counter 1 times a four-clock low phase, first up then down
		modes = 9'h006;
		req(OP_MODE, 2'h0, 16'h0000, 3'h0, 3'h0);
		wave(0, 4'b1001, 4'b0000, 1);
		req(OP_READ, 2'h1, 16'h0000, 3'h0, 3'h0);
		chk(got, exp_pw(4, 1'b0), "width up");
		wave(0, 4'b1001, 4'b1111, 1);
		req(OP_READ, 2'h1, 16'h0000, 3'h0, 3'h0);
		chk(got, exp_pw(4, 1'b1), "width down");
		// b rise clears, six a rises with b low, b rise latches
		modes = 9'h007;
		req(OP_MODE, 2'h0, 16'h0000, 3'h0, 3'h0);
		wave(0, 4'b0000, 4'b0010, 1);
		wave(0, 4'b0101, 4'b0000, 3);
		wave(0, 4'b0000, 4'b0010, 1);
		req(OP_READ, 2'h1, 16'h0000, 3'h0, 3'h0);
		chk(got, 16'h0006, "frequency");
		test_done();
	end
endmodule // tb_top
`default_nettype wire
